// ===== include/eeprom_host_defines.svh
`ifndef EEPROM_HOST_DEFINES_SVH
`define EEPROM_HOST_DEFINES_SVH

// Register byte offsets of the controller's own register file.
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_WDATA 4'h8
`define REG_STATUS 4'hC

// Control register field positions.
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 1
`define CTRL_OP_MSB 2
`define CTRL_STRAP_LSB 4
`define CTRL_STRAP_MSB 5
`define CTRL_NOSTOP_BIT 6
`define CTRL_RECOVER_BIT 7

// Status register field positions.
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1
`define STAT_RDATA_LSB 8

// Reset values.
`define CTRL_RESET 8'h00
`define ADDR_RESET 16'h0000

// Fixed class pattern of the device address word.
`define DEV_CLASS 5'h14

// Serial clock quarter period: 100 MHz / 400 kHz / 4, rounded up = 63 cycles.
`define SYS_CLK_HZ 100000000
`define SCL_HZ 400000
`define QUARTER_CYCLES ((`SYS_CLK_HZ + 4 * `SCL_HZ - 1) / (4 * `SCL_HZ))

// Largest number of clocks sent during bus recovery.
`define RECOVER_CLOCKS 9

`endif

// ===== include/eeprom_host_pkg.sv
package eeprom_host_pkg;

  // Operation requested by software.
  typedef enum logic [1:0]
  {
    OP_WRITE,
    OP_READ_CUR,
    OP_READ_RAND,
    OP_POLL
  } op_t;

  // Bit-level commands sent to the bit engine.
  typedef enum logic [2:0]
  {
    BIT_START,
    BIT_STOP,
    BIT_WRITE,
    BIT_READ,
    BIT_CLOCK
  } bitcmd_t;

endpackage : eeprom_host_pkg

// ===== src/bit_engine.sv
`include "eeprom_host_defines.svh"

module bit_engine
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic cmdValid, // One-cycle pulse starting a bit command.
  input wire eeprom_host_pkg::bitcmd_t cmd, // Bit command to perform.
  input wire logic txBit, // Bit to send on a write.
  input wire logic sdaIn, // Synchronised data line level.
  output logic done, // One-cycle pulse when the command completes.
  output logic rxBit, // Bit sampled at the clock high point.
  output logic scl, // Serial clock output, registered.
  output logic sdaOe // Data line pull-low enable, registered.
);

  logic [7:0] tick_ff; // Quarter-period divider.
  logic [1:0] phase_ff; // Quarter within the current bit.
  logic busy_ff; // A command is under way.
  eeprom_host_pkg::bitcmd_t cmd_ff; // Command being performed.
  logic txBit_ff; // Held bit to send.
  logic quarter; // One-cycle enable at each quarter period.

  assign quarter = busy_ff && (tick_ff == 8'(`QUARTER_CYCLES - 1));

  // Quarter-period divider runs only during a command.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !busy_ff || quarter)
      tick_ff <= 8'h00;
    else
      tick_ff <= tick_ff + 8'h01;
  end

  // Command sequencing over four quarters of a bit time.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_ff <= 1'b0;
      phase_ff <= 2'h0;
      cmd_ff <= eeprom_host_pkg::BIT_STOP;
      txBit_ff <= 1'b1;
      done <= 1'b0;
      rxBit <= 1'b1;
      scl <= 1'b1;
      sdaOe <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy_ff)
      begin
        // Accept a command and hold it.
        if (cmdValid)
        begin
          busy_ff <= 1'b1;
          phase_ff <= 2'h0;
          cmd_ff <= cmd;
          txBit_ff <= txBit;
        end
      end
      else if (quarter)
      begin
        phase_ff <= phase_ff + 2'h1;
        case (cmd_ff)
          eeprom_host_pkg::BIT_START:
          begin
            // Release data, raise clock, then pull data low with clock high.
            case (phase_ff)
              2'h0: sdaOe <= 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: sdaOe <= 1'b1;
              default: scl <= 1'b0;
            endcase
          end
          eeprom_host_pkg::BIT_STOP:
          begin
            // Pull data low with clock low, raise clock, then release data.
            case (phase_ff)
              2'h0: sdaOe <= 1'b1;
              2'h1: scl <= 1'b1;
              2'h2: sdaOe <= 1'b0;
              default: scl <= 1'b1;
            endcase
          end
          default:
          begin
            // Data changes only while the clock is low; sample at clock high.
            case (phase_ff)
              2'h0: sdaOe <= (cmd_ff == eeprom_host_pkg::BIT_WRITE) ? !txBit_ff : 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: rxBit <= sdaIn;
              default: scl <= 1'b0;
            endcase
          end
        endcase
        if (phase_ff == 2'h3)
        begin
          busy_ff <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : bit_engine

// ===== src/eeprom_host.sv
`include "eeprom_host_defines.svh"

module eeprom_host
(
  input wire logic clk, // System clock, 100 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [3:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [3:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic sclOut, // Serial clock drive level.
  output logic sclOe, // Serial clock drive enable.
  input wire logic sdaIn, // Data line level at the pin.
  output logic sdaOut, // Data line drive level, always low.
  output logic sdaOe // Data line pull-low enable.
);

  typedef enum logic [3:0]
  {
    S_IDLE,
    S_RECOVER,
    S_START,
    S_SEND,
    S_ACK,
    S_RECV,
    S_MACK,
    S_STOP
  } state_t;

  state_t state_ff; // Sequencer state.
  logic [7:0] ctrl_ff; // Control register.
  logic [15:0] addr_ff; // Word address register.
  logic [7:0] wdata_ff; // Data byte to write.
  logic [7:0] rdata_ff; // Last byte read.
  logic nack_ff; // Last command saw a missing acknowledge.
  logic busy_ff; // A command is under way.
  logic [7:0] shift_ff; // Byte shift register.
  logic [3:0] bitCnt_ff; // Bits left in the current byte or recovery clocks.
  logic [2:0] step_ff; // Byte index within the command.
  logic readPhase_ff; // Second address phase of a random read.
  logic issue_ff; // Pulse to the bit engine.
  eeprom_host_pkg::bitcmd_t bcmd_ff; // Bit command to issue.
  logic txBit_ff; // Bit offered to the bit engine.
  logic bitDone; // Bit engine completion pulse.
  logic rxBit; // Bit engine sample.
  logic sdaSync; // Synchronised data line.
  logic sclReg; // Bit engine clock level.
  logic sdaOeReg; // Bit engine data enable.
  logic goPulse; // Software start of a command.
  logic [1:0] bresp_ff; // Held write response.
  eeprom_host_pkg::op_t op; // Requested operation.
  logic awHeld_ff; // Write address captured.
  logic wHeld_ff; // Write data captured.
  logic [3:0] awAddr_ff; // Captured write address.
  logic [31:0] wData_ff; // Captured write data.

  assign op = eeprom_host_pkg::op_t'(ctrl_ff[`CTRL_OP_MSB:`CTRL_OP_LSB]);

  // Device address word: fixed class, two straps, direction bit.
  function automatic logic [7:0] devWord(input logic [1:0] strap, input logic rd);
    devWord = {`DEV_CLASS, strap, rd};
  endfunction : devWord

  pin_sync u_sdaSync
  (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(sdaIn),
    .pinOut(sdaSync)
  );

  bit_engine u_bits
  (
    .clk(clk),
    .rst_n(rst_n),
    .cmdValid(issue_ff),
    .cmd(bcmd_ff),
    .txBit(txBit_ff),
    .sdaIn(sdaSync),
    .done(bitDone),
    .rxBit(rxBit),
    .scl(sclReg),
    .sdaOe(sdaOeReg)
  );

  // Drive pins straight from flip-flops; the clock is pushed high and low.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sclOut <= 1'b1;
      sclOe <= 1'b1;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
    end
    else
    begin
      sclOut <= sclReg;
      sclOe <= 1'b1;
      sdaOut <= 1'b0;
      sdaOe <= sdaOeReg;
    end
  end

  // Write channel: capture address and data in either order, then answer.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 4'h0;
      wData_ff <= 32'h0;
      s_axi_bvalid <= 1'b0;
      bresp_ff <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
      end
      if (awHeld_ff && wHeld_ff && !s_axi_bvalid)
      begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Offsets that are not word aligned answer with a slave error.
        bresp_ff <= (awAddr_ff[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
  assign s_axi_bresp = bresp_ff;
  assign goPulse = awHeld_ff && wHeld_ff && !s_axi_bvalid && (awAddr_ff == `REG_CTRL)
                   && wData_ff[`CTRL_GO_BIT] && !busy_ff;

  // Register writes; writes to every register are ignored while a command runs.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= `CTRL_RESET;
      addr_ff <= `ADDR_RESET;
      wdata_ff <= 8'h00;
    end
    else if (awHeld_ff && wHeld_ff && !s_axi_bvalid && !busy_ff)
    begin
      case (awAddr_ff)
        `REG_CTRL: if (s_axi_wstrb[0]) ctrl_ff <= wData_ff[7:0];
        `REG_ADDR: if (s_axi_wstrb[1:0] == 2'h3) addr_ff <= wData_ff[15:0];
        `REG_WDATA: if (s_axi_wstrb[0]) wdata_ff <= wData_ff[7:0];
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `REG_CTRL: s_axi_rdata <= {24'h0, ctrl_ff};
        `REG_ADDR: s_axi_rdata <= {16'h0, addr_ff};
        `REG_WDATA: s_axi_rdata <= {24'h0, wdata_ff};
        `REG_STATUS: s_axi_rdata <= {16'h0, rdata_ff, 6'h0, nack_ff, busy_ff};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Command sequencer: issues bit commands and waits for each to finish.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff <= S_IDLE;
      busy_ff <= 1'b0;
      nack_ff <= 1'b0;
      rdata_ff <= 8'h00;
      shift_ff <= 8'h00;
      bitCnt_ff <= 4'h0;
      step_ff <= 3'h0;
      readPhase_ff <= 1'b0;
      issue_ff <= 1'b0;
      bcmd_ff <= eeprom_host_pkg::BIT_STOP;
      txBit_ff <= 1'b1;
    end
    else
    begin
      issue_ff <= 1'b0;
      case (state_ff)
        S_IDLE:
        begin
          if (goPulse)
          begin
            busy_ff <= 1'b1;
            nack_ff <= 1'b0;
            readPhase_ff <= 1'b0;
            step_ff <= 3'h0;
            if (wData_ff[`CTRL_RECOVER_BIT])
            begin
              state_ff <= S_RECOVER;
              bitCnt_ff <= 4'(`RECOVER_CLOCKS);
            end
            else
            begin
              state_ff <= S_START;
              issue_ff <= 1'b1;
              bcmd_ff <= eeprom_host_pkg::BIT_START;
            end
          end
        end
        S_RECOVER:
        begin
          // Clock until the data line is seen high, at most nine times, then start.
          if (!issue_ff && (bitCnt_ff == 4'(`RECOVER_CLOCKS) || bitDone))
          begin
            if ((bitDone && rxBit) || bitCnt_ff == 4'h0)
            begin
              state_ff <= S_START;
              issue_ff <= 1'b1;
              bcmd_ff <= eeprom_host_pkg::BIT_START;
            end
            else
            begin
              bitCnt_ff <= bitCnt_ff - 4'h1;
              issue_ff <= 1'b1;
              bcmd_ff <= eeprom_host_pkg::BIT_CLOCK;
            end
          end
        end
        S_START:
        begin
          // Every start is followed by the device address word.
          if (bitDone)
          begin
            shift_ff <= devWord(ctrl_ff[`CTRL_STRAP_MSB:`CTRL_STRAP_LSB],
                                (op == eeprom_host_pkg::OP_READ_CUR) || readPhase_ff);
            step_ff <= 3'h0;
            bitCnt_ff <= 4'h8;
            state_ff <= S_SEND;
          end
        end
        S_SEND:
        begin
          // Shift a byte out most significant bit first, then clock the ninth bit.
          if (!issue_ff && (bitDone || bitCnt_ff == 4'h8))
          begin
            issue_ff <= 1'b1;
            if (bitCnt_ff == 4'h0)
            begin
              bcmd_ff <= eeprom_host_pkg::BIT_READ;
              state_ff <= S_ACK;
            end
            else
            begin
              bcmd_ff <= eeprom_host_pkg::BIT_WRITE;
              txBit_ff <= shift_ff[7];
              shift_ff <= {shift_ff[6:0], 1'b0};
              bitCnt_ff <= bitCnt_ff - 4'h1;
            end
          end
        end
        S_ACK:
        begin
          if (bitDone)
          begin
            bitCnt_ff <= 4'h8;
            if (rxBit)
            begin
              // No acknowledge: a busy target or a mismatch ends the command.
              nack_ff <= 1'b1;
              state_ff <= S_STOP;
              issue_ff <= 1'b1;
              bcmd_ff <= eeprom_host_pkg::BIT_STOP;
            end
            else if (op == eeprom_host_pkg::OP_POLL && step_ff == 3'h0)
            begin
              state_ff <= S_STOP;
              issue_ff <= 1'b1;
              bcmd_ff <= eeprom_host_pkg::BIT_STOP;
            end
            else if (op == eeprom_host_pkg::OP_READ_CUR || readPhase_ff)
            begin
              // Read direction: the target shifts out from its own counter.
              state_ff <= S_RECV;
              issue_ff <= 1'b1;
              bcmd_ff <= eeprom_host_pkg::BIT_READ;
            end
            else if (step_ff == 3'h0 || step_ff == 3'h1)
            begin
              // Two word address bytes, high byte first.
              shift_ff <= (step_ff == 3'h0) ? addr_ff[15:8] : addr_ff[7:0];
              step_ff <= step_ff + 3'h1;
              state_ff <= S_SEND;
            end
            else if (step_ff == 3'h2 && op == eeprom_host_pkg::OP_READ_RAND)
            begin
              // Dummy write done: repeated start with read direction.
              readPhase_ff <= 1'b1;
              state_ff <= S_START;
              issue_ff <= 1'b1;
              bcmd_ff <= eeprom_host_pkg::BIT_START;
            end
            else if (step_ff == 3'h2)
            begin
              shift_ff <= wdata_ff;
              step_ff <= 3'h3;
              state_ff <= S_SEND;
            end
            else
            begin
              // Data byte taken; a stop lets the target start its write cycle.
              state_ff <= S_STOP;
              issue_ff <= 1'b1;
              bcmd_ff <= eeprom_host_pkg::BIT_STOP;
            end
          end
        end
        S_RECV:
        begin
          // Collect eight bits sampled at clock high.
          if (bitDone)
          begin
            shift_ff <= {shift_ff[6:0], rxBit};
            bitCnt_ff <= bitCnt_ff - 4'h1;
            issue_ff <= 1'b1;
            if (bitCnt_ff == 4'h1)
            begin
              state_ff <= S_MACK;
              rdata_ff <= {shift_ff[6:0], rxBit};
              bcmd_ff <= eeprom_host_pkg::BIT_WRITE;
              txBit_ff <= 1'b1;
            end
            else
              bcmd_ff <= eeprom_host_pkg::BIT_READ;
          end
        end
        S_MACK:
        begin
          if (bitDone)
          begin
            state_ff <= S_STOP;
            issue_ff <= 1'b1;
            bcmd_ff <= eeprom_host_pkg::BIT_STOP;
          end
        end
        S_STOP:
        begin
          if (bitDone)
          begin
            busy_ff <= 1'b0;
            state_ff <= S_IDLE;
          end
        end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

endmodule : eeprom_host

// ===== src/pin_sync.sv
module pin_sync
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic pinIn, // Asynchronous pin level.
  output logic pinOut // Synchronised pin level.
);

  logic stage1_ff; // First stage, read only by the second stage.
  logic stage2_ff; // Second stage.

  // Two flip-flops bring the pin into the clock domain; reset reads high as an idle bus.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1_ff <= 1'b1;
      stage2_ff <= 1'b1;
    end
    else
    begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign pinOut = stage2_ff;

endmodule : pin_sync

// ===== test/eeprom_host_props.sv
`include "eeprom_host_defines.svh"

module eeprom_host_props
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic s_axi_bvalid, // Write answer.
  input wire logic s_axi_bready, // Write answer taken.
  input wire logic [1:0] s_axi_bresp, // Write code.
  input wire logic s_axi_rvalid, // Read answer.
  input wire logic s_axi_rready, // Read answer taken.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic sclOut, // Serial clock level.
  input wire logic sdaIn, // Data line level.
  input wire logic sdaOe // Data line pulled low.
);
  localparam logic [4:0] CLS = `DEV_CLASS; // Class pattern.
  logic prevOe_ff; // Last pull enable.
  logic prevScl_ff; // Last clock level.
  logic frame_ff; // Inside a frame.
  logic first_ff; // In the address word.
  logic [3:0] bit_ff; // Clock rises so far in the word.
  wire rise = sclOut && !prevScl_ff; // Clock rises now.
  wire high = sclOut && prevScl_ff; // Clock stays high.

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Follows frames and counts clock rises in each word.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prevOe_ff <= 1'b0;
      prevScl_ff <= 1'b1;
      frame_ff <= 1'b0;
      first_ff <= 1'b0;
      bit_ff <= 4'h0;
    end
    else
    begin
      prevOe_ff <= sdaOe;
      prevScl_ff <= sclOut;
      if (high && sdaOe && !prevOe_ff)
      begin
        frame_ff <= 1'b1;
        first_ff <= 1'b1;
        bit_ff <= 4'h0;
      end
      else if (high && !sdaOe && prevOe_ff)
        frame_ff <= 1'b0;
      else if (rise)
      begin
        bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
        first_ff <= first_ff && (bit_ff != 4'h8);
      end
    end
  end

  data_setup_a:
    assert property (!sclOut && sdaOe != prevOe_ff |-> !sclOut [*8])
    else $error("data moved too close to a clock rise");
  data_hold_a:
    assert property (rise |-> sdaOe == prevOe_ff ##1 $stable(sdaOe))
    else $error("data moved at a clock rise");
  start_high_a:
    assert property (high && $rose(sdaOe) |-> $past(sdaIn))
    else $error("start made on a low line");
  stop_idle_a:
    assert property (high && $fell(sdaOe) |=> (sclOut && !sdaOe) [*8])
    else $error("bus not idle after stop");
  class_bits_a:
    assert property (rise && frame_ff && first_ff && bit_ff < 4'h5 |-> sdaOe == !CLS[3'h4 - bit_ff[2:0]])
    else $error("wrong class bit in address word");
  ack_release_a:
    assert property (rise && frame_ff && bit_ff == 4'h8 |-> !sdaOe)
    else $error("line held on the ninth clock");
  nack_stop_a:
    assert property (rise && frame_ff && first_ff && bit_ff == 4'h8 && sdaIn |-> ##[1:400] (high && $fell(sdaOe)))
    else $error("no stop after refused address");
  answer_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule : eeprom_host_props

bind eeprom_host eeprom_host_props u_eeprom_host_props
(
  .clk(clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .sclOut(sclOut),
  .sdaIn(sdaIn), .sdaOe(sdaOe)
);

// ===== test/eeprom_model.sv
module eeprom_model
#(
  parameter logic [1:0] STRAP = 2'h1, // Strap levels.
  parameter int WRITE_NS = 40000 // Internal write time, shortened.
)
(
  input wire logic scl, // Serial clock.
  input wire logic sda, // Resolved data line.
  input wire logic wp, // Write protect.
  output logic pullLow // Device pulls the line low.
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef enum {DEV, AHI, ALO, DAT, RD, IDLE} phase_t;
  phase_t ph = IDLE; // Standby at power-up.
  logic [7:0] mem [65536]; // Memory array.
  logic [15:0] ptr = 16'h0000; // Address counter.
  logic [7:0] sh = 8'h00; // Incoming word.
  int cnt = 0; // Clock rises in the word.
  logic wrote = 1'b0; // Data taken since the start.
  time busyEnd = 0; // End of the internal write.

  // Known pattern: each byte is its low address bits XOR 3C.
  initial
  begin
    pullLow = 1'b0;
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ 8'h3C;
  end

  // A falling line with the clock high opens a frame.
  always @(negedge sda)
    if (scl)
    begin
      ph = DEV;
      cnt = 0;
      wrote = 1'b0;
    end

  // A rising line with the clock high ends it and starts any write.
  always @(posedge sda)
    if (scl)
    begin
      if (wrote)
        busyEnd = $time + WRITE_NS;
      wrote = 1'b0;
      ph = IDLE;
    end

  // Bits are taken on the rising clock; a read ends on a missing acknowledge.
  always @(posedge scl)
    if (ph != IDLE)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      else if (ph == RD && sda)
        ph = IDLE;
      cnt++;
    end

  // The line changes only after the falling clock.
  always @(negedge scl)
    if (ph != IDLE)
    begin
      pullLow = 1'b0;
      if (cnt == 9)
        cnt = 0;
      if (cnt == 8 && ph == RD)
        ptr++;
      else if (cnt == 8)
      begin
        case (ph)
          DEV: ph = (sh[7:3] == 5'h14 && sh[2:1] == STRAP && $time >= busyEnd) ? (sh[0] ? RD : AHI) : IDLE;
          AHI: {ph, ptr[15:8]} = {ALO, sh};
          ALO: {ph, ptr[7:0]} = {DAT, sh};
          DAT:
          begin
            if (!wp)
              {mem[ptr], wrote} = {sh, 1'b1};
            ptr[6:0]++;
          end
          default: ;
        endcase
        pullLow = (ph != IDLE);
      end
      if (ph == RD && cnt < 8)
        pullLow = !mem[ptr][7 - cnt];
    end
endmodule : eeprom_model

// ===== test/serial_eeprom_two_wire_target_test.sv
`include "eeprom_host_defines.svh"

module serial_eeprom_two_wire_target_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [1:0] op; // Operation code.
    logic [1:0] st;
    logic rec;
    logic wp;
    logic [15:0] ad;
    logic [7:0] wd;
    logic nack;
    logic rdChk;
    logic [7:0] rd;
    int gap;
  } row_t;
  logic clk;
  logic rst_n = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic wp = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sclOut, sclOe, sdaOut, sdaOe, pullLow;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, s;
  int nErrors = 0;
  int checks = 0;
  // Open-drain line with a pull-up: low while either party pulls.
  wire line = !((sdaOe && !sdaOut) || pullLow);
  // Ordinary cases: operation and inputs beside the outcome.
  row_t rows [10] = '{
    '{2'h0, 2'h1, 1'b0, 1'b0, 16'h1234, 8'hA5, 1'b0, 1'b0, 8'h00, 0},
    '{2'h3, 2'h1, 1'b0, 1'b0, 16'h0, 8'h00, 1'b1, 1'b0, 8'h00, 5000},
    '{2'h3, 2'h1, 1'b0, 1'b0, 16'h0, 8'h00, 1'b0, 1'b0, 8'h00, 0},
    '{2'h2, 2'h1, 1'b0, 1'b0, 16'h1234, 8'h00, 1'b0, 1'b1, 8'hA5, 0},
    '{2'h2, 2'h2, 1'b0, 1'b0, 16'h1234, 8'h00, 1'b1, 1'b0, 8'h00, 0},
    '{2'h0, 2'h1, 1'b0, 1'b1, 16'h1235, 8'h5A, 1'b0, 1'b0, 8'h00, 0},
    '{2'h2, 2'h1, 1'b0, 1'b0, 16'h1235, 8'h00, 1'b0, 1'b1, 8'h09, 0},
    '{2'h2, 2'h1, 1'b0, 1'b0, 16'hFFFF, 8'h00, 1'b0, 1'b1, 8'hC3, 0},
    '{2'h1, 2'h1, 1'b0, 1'b0, 16'h0, 8'h00, 1'b0, 1'b1, 8'h3C, 0},
    '{2'h1, 2'h1, 1'b1, 1'b0, 16'h0, 8'h00, 1'b0, 1'b1, 8'h3D, 0}
  };

  eeprom_host u_eeprom_host
  (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(line),
    .sdaOut(sdaOut), .sdaOe(sdaOe)
  );

  eeprom_model u_eeprom_model (.scl(sclOut), .sda(line), .wp(wp), .pullLow(pullLow));

  // Compares and counts; reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One register write; each channel is released when taken.
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axiWr

  // One register read.
  task automatic axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axiRd

  // Loads the registers, starts the command and waits while busy.
  task automatic runOp(input row_t w, output logic [31:0] st);
    logic [1:0] rs;
    axiWr(`REG_ADDR, {16'h0, w.ad}, rs);
    axiWr(`REG_WDATA, {24'h0, w.wd}, rs);
    axiWr(`REG_CTRL, {24'h0, w.rec, 1'b0, w.st, 1'b0, w.op, 1'b1}, rs);
    st = 32'h00000001;
    while (st[0] !== 1'b0)
      axiRd(`REG_STATUS, st, rs);
  endtask : runOp

  // Prints the verdict and ends the run.
  task automatic giveVerdict();
    if (nErrors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : giveVerdict

  // Clock of 10 ns.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short.
  initial
  begin
    repeat (95000) @(posedge clk);
    nErrors++;
    giveVerdict();
  end

  // Table rows, then refusals and a mid-run reset.
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      wp <= rows[i].wp;
      runOp(rows[i], s);
      check("address refused", {31'h0, s[1]}, {31'h0, rows[i].nack});
      if (rows[i].rdChk)
        check("read byte", {24'h0, s[15:8]}, {24'h0, rows[i].rd});
      repeat (rows[i].gap) @(posedge clk);
    end
    axiWr(4'h2, 32'h0, r);
    check("unaligned write", {30'h0, r}, 32'h2);
    axiRd(4'h6, s, r);
    check("unmapped read", {r, s[29:0]}, 32'h80000000);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    check("lines in reset", {30'h0, sclOut, sdaOe}, 32'h2);
    rst_n <= 1'b1;
    @(posedge clk);
    runOp(rows[9], s);
    check("counter kept", {24'h0, s[15:8]}, 32'h3E);
    giveVerdict();
  end
endmodule : serial_eeprom_two_wire_target_test
